// ---- hw/lane_code_error_threshold_status.sv ----
// Per-lane decode error threshold status with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "lane_err_regs.svh"
module lane_code_error_threshold_status
	import lane_err_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire lane_err_pkg::apb_addr_t paddr,
	input wire lane_err_pkg::apb_data_t pwdata,
	output lane_err_pkg::apb_data_t prdata,
	output logic pready,
	output logic pslverr,
	input wire lane_err_pkg::lane_vec_t invalid_code_err_link0,
	input wire lane_err_pkg::lane_vec_t invalid_code_err_link1,
	input wire lane_err_pkg::lane_vec_t stray_control_char_err_link0,
	input wire lane_err_pkg::lane_vec_t stray_control_char_err_link1
);
	import lane_err_pkg::*;

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	logic link_select;
	count_t error_count_threshold;

	// ----------------------------------------
	// Per-lane flags of each link and error type
	// ----------------------------------------
	wire lane_vec_t invalid_flags_link0;
	wire lane_vec_t invalid_flags_link1;
	wire lane_vec_t stray_flags_link0;
	wire lane_vec_t stray_flags_link1;

	// ----------------------------------------
	// Paged status views
	// ----------------------------------------
	wire lane_vec_t invalid_code_lane_status;
	wire lane_vec_t unexpected_control_char_lane_status;

	// ----------------------------------------
	// One counter per lane, link and type
	// ----------------------------------------
	genvar lane;
	generate
		for (lane = 0; lane < 8; lane++) begin : g_lane
			lane_error_counter u_invalid_link0 (
				.pclk(pclk),
				.presetn(presetn),
				.err_pulse(invalid_code_err_link0[lane]),
				.threshold(error_count_threshold),
				.flag(invalid_flags_link0[lane])
			);

			lane_error_counter u_invalid_link1 (
				.pclk(pclk),
				.presetn(presetn),
				.err_pulse(invalid_code_err_link1[lane]),
				.threshold(error_count_threshold),
				.flag(invalid_flags_link1[lane])
			);

			lane_error_counter u_stray_link0 (
				.pclk(pclk),
				.presetn(presetn),
				.err_pulse(stray_control_char_err_link0[lane]),
				.threshold(error_count_threshold),
				.flag(stray_flags_link0[lane])
			);

			lane_error_counter u_stray_link1 (
				.pclk(pclk),
				.presetn(presetn),
				.err_pulse(stray_control_char_err_link1[lane]),
				.threshold(error_count_threshold),
				.flag(stray_flags_link1[lane])
			);

			// Software sees only the link chosen by the page
			assign invalid_code_lane_status[lane] =
				link_select ? invalid_flags_link1[lane] : invalid_flags_link0[lane];

			assign unexpected_control_char_lane_status[lane] =
				link_select ? stray_flags_link1[lane] : stray_flags_link0[lane];
		end
	endgenerate

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	wire [10:0] reg_index = paddr[12:2];
	wire access = psel && penable && !pready;
	wire read_now = access && !pwrite;
	wire write_now = access && pwrite;

	wire hit_page = (reg_index == `LINK_PAGE_IDX);
	wire hit_invalid = (reg_index == `INVALID_CODE_IDX);
	wire hit_stray = (reg_index == `STRAY_CTRL_IDX);
	wire hit_thr = (reg_index == `THRESHOLD_IDX);
	wire mapped = hit_page || hit_invalid || hit_stray || hit_thr;

	// Status registers have no write strobe at all
	wire write_page = write_now && hit_page;
	wire write_thr = write_now && hit_thr;

	// ----------------------------------------
	// Read words
	// ----------------------------------------
	wire apb_data_t page_word = {31'h0, link_select};
	wire apb_data_t invalid_word = {24'h0, invalid_code_lane_status};
	wire apb_data_t stray_word = {24'h0, unexpected_control_char_lane_status};
	wire apb_data_t threshold_word = {24'h0, error_count_threshold};

	wire apb_data_t read_value =
		hit_page ? page_word :
		hit_invalid ? invalid_word :
		hit_stray ? stray_word :
		hit_thr ? threshold_word :
		32'h0000_0000;

	// ----------------------------------------
	// Next values
	// ----------------------------------------
	wire next_link_select = write_page ? pwdata[`LINK_PAGE_POS] : link_select;
	wire count_t next_error_count_threshold = write_thr ? pwdata[7:0] : error_count_threshold;
	wire next_pready = access;
	wire next_pslverr = access && !mapped;
	wire apb_data_t next_prdata = read_now ? read_value : 32'h0000_0000;

	// ----------------------------------------
	// Link page register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_select <= `LINK_PAGE_RESET;
		end else begin
			link_select <= next_link_select;
		end
	end

	// ----------------------------------------
	// Threshold register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			error_count_threshold <= `THRESHOLD_RESET;
		end else begin
			error_count_threshold <= next_error_count_threshold;
		end
	end

	// ----------------------------------------
	// Bus answer, one wait state
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= next_pready;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= next_pslverr;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else begin
			prdata <= next_prdata;
		end
	end
endmodule : lane_code_error_threshold_status
`default_nettype wire

// ---- hw/lane_err_pkg.sv ----
// Shared types of the lane error status block
package lane_err_pkg;
	typedef logic [7:0] lane_vec_t;
	typedef logic [7:0] count_t;
	typedef logic [12:0] apb_addr_t;
	typedef logic [31:0] apb_data_t;
endpackage : lane_err_pkg

// ---- hw/lane_err_regs.svh ----
// Register map and reset values of the lane error status block
//
// Functional notes
// - Invalid-code flags, lanes 7..0 at bits 7..0
// - Invalid-code flag set when count reaches threshold
// - Stray control-char flags at 0x46F, bit n lane n
// - Stray control-char flag set when count reaches threshold
// - Status reads follow link-select page at 0x300
// - Flags read-only, zero after reset
`ifndef LANE_ERR_REGS_SVH
`define LANE_ERR_REGS_SVH

// ----------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------
`define LINK_PAGE_IDX 11'h300
`define INVALID_CODE_IDX 11'h46e
`define STRAY_CTRL_IDX 11'h46f
`define THRESHOLD_IDX 11'h4a0

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define LINK_PAGE_POS 0
`define LINK_PAGE_RESET 1'h0
`define THRESHOLD_RESET 8'hff
`define STATUS_RESET 8'h00
`define COUNT_MAX 8'hff

`endif

// ---- hw/lane_error_counter.sv ----
// Saturating error counter with threshold flag for one lane
`timescale 1ns/1ps
`default_nettype none
`include "lane_err_regs.svh"
module lane_error_counter
	import lane_err_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic err_pulse,
	input wire lane_err_pkg::count_t threshold,
	output logic flag
);
	import lane_err_pkg::*;

	count_t count;
	wire count_full = (count == `COUNT_MAX);
	wire at_threshold = (count >= threshold);

	// Count stops at full scale so the flag never falls back by wrapping
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 8'h00;
		end else if (err_pulse && !count_full) begin
			count <= count + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag <= 1'b0;
		end else begin
			flag <= at_threshold;
		end
	end
endmodule : lane_error_counter
`default_nettype wire

// ---- test/lane_code_error_threshold_status_test.sv ----
// Register tests
`timescale 1ns/1ps
`default_nettype none
module lane_code_error_threshold_status_test;
	import lane_err_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	apb_addr_t paddr = 0;
	apb_data_t pwdata = 0, err = 0, prdata;
	lane_vec_t invalid_code_err_link0, invalid_code_err_link1;
	lane_vec_t stray_control_char_err_link0, stray_control_char_err_link1;
	int miscompares = 0, total_checks = 0;
	always #20 pclk = ~pclk;
	err_src src (.*);
	lane_code_error_threshold_status uut (.*);
	task automatic end_sim;
		$display("%0d of %0d failed", miscompares, total_checks);
		if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_sim
	task automatic check(input string what, input apb_data_t seen, exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s exp %h got %h", what, exp, seen);
		end
	endtask : check
	task automatic ap(input logic w, input apb_addr_t a, input apb_data_t d, x, input logic e);
		@(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk) penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		{psel, penable} <= 0;
		check("prdata", prdata, x);
		check("pslverr", {31'h0, pslverr}, {31'h0, e});
	endtask : ap
	task automatic inj(input apb_data_t v, input int n);
		@(posedge pclk) err <= v;
		repeat (n) @(posedge pclk);
		err <= 0;
	endtask : inj
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		ap(0, 13'h1280, 0, 32'hff, 0);
		ap(0, 13'hc00, 0, 0, 0);
		ap(1, 13'h11bc, 255, 0, 0);
		ap(0, 13'h11bc, 0, 0, 0);
		ap(1, 13'h1280, 3, 0, 0);
		ap(0, 13'h1280, 0, 32'h3, 0);
		inj(32'h20, 2);
		ap(0, 13'h11b8, 0, 0, 0);
		inj(32'h20, 1);
		ap(0, 13'h11b8, 0, 32'h20, 0);
		inj(32'h80000000, 3);
		ap(0, 13'h11bc, 0, 0, 0);
		ap(1, 13'hc00, 1, 0, 0);
		ap(0, 13'hc00, 0, 32'h1, 0);
		ap(0, 13'h11bc, 0, 32'h80, 0);
		ap(0, 13'h11b8, 0, 0, 0);
		ap(0, 0, 0, 0, 1);
		end_sim;
	end
	initial begin
		#100000;
		miscompares++;
		end_sim;
	end
endmodule : lane_code_error_threshold_status_test
`default_nettype wire

// ---- test/lane_err_partner.sv ----
// Error pulse source, splits err into the four per-link lane error vectors
`timescale 1ns/1ps
`default_nettype none
module err_src (
	input wire logic [31:0] err,
	output logic [7:0] invalid_code_err_link0,
	output logic [7:0] invalid_code_err_link1,
	output logic [7:0] stray_control_char_err_link0,
	output logic [7:0] stray_control_char_err_link1
);
	assign {stray_control_char_err_link1, stray_control_char_err_link0} = err[31:16];
	assign {invalid_code_err_link1, invalid_code_err_link0} = err[15:0];
endmodule : err_src
`default_nettype wire

// ---- test/lane_err_sva.sv ----
// Bus checker
`timescale 1ns/1ps
`default_nettype none
module lane_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire lane_err_pkg::apb_data_t prdata,
	input wire logic pready,
	input wire logic pslverr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_one_wait: assert property (psel && penable && !pready |=> pready) else $error("late");
	a_ready_pulse: assert property (pready |=> !pready) else $error("long");
	a_ready_access: assert property (pready |-> psel && penable) else $error("stray");
	a_setup_first: assert property (!penable |=> !pready) else $error("early");
	a_err_ready: assert property (pslverr |-> pready) else $error("err");
	a_data_idle: assert property (!pready |-> prdata == 0) else $error("idle");
	a_upper_zero: assert property (pready |-> prdata[31:8] == 0) else $error("upper");
	c_err: cover property (pslverr);
	c_flag: cover property (prdata != 0);
	c_wait: cover property (penable && !pready);
endmodule : lane_sva
bind lane_code_error_threshold_status lane_sva chk (.*);
`default_nettype wire
